// ---- cid_decode.sv ----
/*
 * decode and execute for store-to-file, return-from-interrupt and the
 * legacy configuration load
 * assumes: program memory presents one word per cycle with instrValid;
 * stack, register file and irq logic sit outside on the same clock
 */
`timescale 1ns/1ps
`include "cid_defines.svh"

module cid_decode (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            srst,
   // instruction fetch
   input  wire logic            instrValid,
   input  wire logic [13:0]     instr,
   output logic                 instrReady,
   // core state
   input  wire logic [7:0]      accum,
   input  wire logic [12:0]     stackTopEntry,
   // effects
   output cid_pkg::cid_fwr_s    fileWr,
   output logic                 stackPop,
   output logic [12:0]          pc,
   output logic [7:0]           irqControlReg,
   output logic [7:0]           cfgReg,
   output logic                 statusWr,
   output cid_pkg::cid_op_e     lastOp
);
   import cid_pkg::*;

   // ****************************************************************
   // decode
   // ****************************************************************
   cid_op_e    op;         // class of presented word
   logic       busy;       // second cycle of a return
   logic       take;       // word accepted this cycle
   logic       pcLoad;     // pc load strobe

   // busy for the second return cycle, fetch stalls meanwhile
   assign instrReady = !busy;
   assign take       = instrValid && instrReady;

   // classify the word
   // return and config need exact matches; neighbours fall through to other
   always_comb begin
      if ((instr & `CID_OP_STORE_MASK) == `CID_OP_STORE_VAL) begin
         op = CID_OP_STORE;
      end else if (instr == `CID_OP_RETIRQ) begin
         op = CID_OP_RET;
      end else if (instr == `CID_OP_LOADCFG) begin
         op = CID_OP_CFG;
      end else begin
         op = CID_OP_OTHER;
      end
   end

   // ****************************************************************
   // store to file register
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         fileWr <= '0;
      end else begin
         fileWr.en   <= take && (op == CID_OP_STORE);
         fileWr.addr <= instr[6:0];
         fileWr.data <= accum;
      end
   end

   // address and data follow every cycle; only en marks a write,
   // so the register file must qualify them with en
   // none of these instructions touch the status flags
   assign statusWr = 1'b0;

   // ****************************************************************
   // return from interrupt
   // ****************************************************************
   // pop issued in the second cycle; pc and enable land on its closing edge
   // popping in the stall cycle gives the stack top a cycle to settle
   always_ff @(posedge clk) begin
      if (srst) begin
         busy <= 1'b0;
      end else begin
         busy <= take && (op == CID_OP_RET);
      end
   end

   assign stackPop = busy;
   assign pcLoad   = busy;

   cid_pc_reg u_pc (
      .clk     (clk),
      .srst    (srst),
      .load    (pcLoad),
      .loadVal (stackTopEntry),
      .pc      (pc)
   );

   // enable bit set by the return, other bits kept
   // no clear path here: the irq logic outside owns the clear
   always_ff @(posedge clk) begin
      if (srst) begin
         irqControlReg <= `CID_CTRL_RESET;
      end else if (busy) begin
         irqControlReg[`CID_GIE_BIT] <= 1'b1;
      end
   end

   // ****************************************************************
   // legacy configuration load
   // ****************************************************************
   // kept only for old code; new code should address the register
   // trade-off: a second write path costs one mux on the register
   always_ff @(posedge clk) begin
      if (srst) begin
         cfgReg <= `CID_CFG_RESET;
      end else if (take && (op == CID_OP_CFG)) begin
         cfgReg <= accum;
      end
   end

   // last executed class, for observation
   // lets a monitor see decode results without probing inside
   always_ff @(posedge clk) begin
      if (srst) begin
         lastOp <= CID_OP_OTHER;
      end else if (take) begin
         lastOp <= op;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // acceptance is judged at the fetch port, as the memory sees it;
   // a refused word in the stall cycle never starts a sequence
   sequence s_retTaken;
      instrValid && instrReady && (instr == `CID_OP_RETIRQ);
   endsequence

   a_store_write: assert property (@(posedge clk) disable iff (srst)
      (take && (op == CID_OP_STORE)) |=> (fileWr.en
         && fileWr.addr == $past(instr[6:0]) && fileWr.data == $past(accum)))
      else $error("store did not write accumulator");
   a_ret_pop: assert property (@(posedge clk) disable iff (srst)
      s_retTaken |=> stackPop)
      else $error("return did not pop");
   a_ret_gie: assert property (@(posedge clk) disable iff (srst)
      s_retTaken |=> ##1 irqControlReg[7])
      else $error("return did not set enable");
   a_ret_stall: assert property (@(posedge clk) disable iff (srst)
      s_retTaken |=> !instrReady ##1 instrReady)
      else $error("return not two cycles");
   a_pc_tos: assert property (@(posedge clk) disable iff (srst)
      s_retTaken ##1 1'b1 |=> pc == $past(stackTopEntry))
      else $error("pc not loaded from stack top");
   a_cfg_load: assert property (@(posedge clk) disable iff (srst)
      (take && (op == CID_OP_CFG)) |=> cfgReg == $past(accum))
      else $error("config not loaded");
   a_no_status: assert property (@(posedge clk) disable iff (srst)
      !statusWr)
      else $error("status written");
   a_pc_hold: assert property (@(posedge clk) disable iff (srst)
      !busy |=> pc == $past(pc))
      else $error("pc changed without return");

   // ****************************************************************
   // refusal, pulse width and hold checks
   // ****************************************************************
   // an accepted word that none of the three instructions claims
   sequence s_otherTaken;
      take && (op == CID_OP_OTHER);
   endsequence

   // the stall cycle of a return: pop out and fetch refused together
   sequence s_retSecond;
      stackPop && !instrReady;
   endsequence

   // stall shape: pop with refusal, then fetch resumes with no pop
   a_ret_shape: assert property (@(posedge clk) disable iff (srst)
      s_retTaken |=> s_retSecond ##1 (instrReady && !stackPop))
      else $error("return stall misshaped");
   // a word offered in the stall cycle must wait for the next one
   a_ret_refuse: assert property (@(posedge clk) disable iff (srst)
      busy |-> !take)
      else $error("word taken in return stall");

   // one pop per return, even for returns back to back
   a_pop_pulse: assert property (@(posedge clk) disable iff (srst)
      stackPop |=> !stackPop)
      else $error("pop held longer than one cycle");
   // a pop only ever follows an accepted return word
   a_pop_cause: assert property (@(posedge clk) disable iff (srst)
      stackPop |-> $past(take && (op == CID_OP_RET)))
      else $error("pop without a return");

   // the file write port stays quiet for anything but a store
   a_write_only: assert property (@(posedge clk) disable iff (srst)
      (take && (op != CID_OP_STORE)) |=> !fileWr.en)
      else $error("file written by a non-store word");
   // words outside the subset write no file register, pop nothing and stall no fetch
   a_other_idle: assert property (@(posedge clk) disable iff (srst)
      s_otherTaken |=> (!fileWr.en && !stackPop && instrReady))
      else $error("ignored word had an effect");

   // the configuration register moves only on the legacy load
   a_cfg_hold: assert property (@(posedge clk) disable iff (srst)
      !(take && (op == CID_OP_CFG)) |=> cfgReg == $past(cfgReg))
      else $error("config changed without a load");
   // the control register changes only in the second return cycle
   a_ctrl_keep: assert property (@(posedge clk) disable iff (srst)
      !busy |=> irqControlReg == $past(irqControlReg))
      else $error("control changed without a return");

endmodule

// ---- cid_decode_tb.sv ----
/* self-checking bench for the decoder
   assumes: package and defines compiled first; assertions in design */
`timescale 1ns/1ps
module cid_decode_tb;
   import cid_pkg::*;
   typedef struct packed {cid_op_e k; logic [14:0] v;} cid_note_s;
   logic        clk = 0, srst = 1, slow = 0, instrValid, instrReady;
   logic        statusWr, stackPop;
   logic [13:0] instr;
   logic [7:0]  accum = 0, irqControlReg, cfgReg;
   logic [12:0] stackTopEntry = 0, pc;
   logic [15:0] rnd = 16'h0007;  // lfsr state
   cid_fwr_s    fileWr;
   cid_op_e     lastOp;
   cid_note_s   notes[$];        // expected effects, oldest first
   int          errors = 0, checked = 0, cycles = 0;
   always #5 clk = ~clk;
   cid_decode i_dut (.clk, .srst, .instrValid, .instr, .instrReady,
      .accum, .stackTopEntry, .fileWr, .stackPop, .pc, .irqControlReg,
      .cfgReg, .statusWr, .lastOp);
   cid_prog_mem i_mem (.clk, .srst, .slow, .instrReady, .instrValid,
      .instr);
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input string n, input logic [14:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // queue a word with the effect it must have
   task automatic send(input logic [13:0] w, cid_op_e k, logic [14:0] v);
      i_mem.push(w);
      notes.push_back('{k, v});
   endtask
   // two edges of reset, then the idle values
   task automatic reset_dut();
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      check("pc", pc, 0);
      check("cfg", cfgReg, 8'hFF);
      check("ctrl", irqControlReg, 8'h00);
      check("op", lastOp, CID_OP_OTHER);
      check("ready", instrReady, 1);
   endtask
   // watcher: every taken word pops the oldest note
   always @(posedge clk) begin
      logic took;
      cid_note_s n;
      took = instrValid && instrReady && !srst;
      #1;
      if (took) begin
         n = notes.pop_front();
         check("status", statusWr, 0);
         check("write", fileWr.en, n.k == CID_OP_STORE);
         check("pop", stackPop, n.k == CID_OP_RET);
         check("class", lastOp, n.k);
         if (n.k == CID_OP_STORE)
            check("file", {fileWr.addr, fileWr.data}, n.v);
         if (n.k == CID_OP_CFG) check("cfg", cfgReg, n.v);
         if (n.k == CID_OP_RET) begin
            check("stall", instrReady, 0);
            @(posedge clk);
            #1;
            check("pc", pc, n.v);
            check("ctrl", irqControlReg, 8'h80);
            check("flags", statusWr, 0);
         end
      end
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      logic [6:0] a;
      reset_dut();
      @(posedge clk);
      for (int r = 0; r < 8; r++) begin
         rnd = lfsr(rnd);
         a = rnd[6:0];
         accum <= rnd[15:8];
         stackTopEntry <= 13'(lfsr(rnd) >> 3);
         slow <= r[0];
         @(negedge clk);
         // boundaries, refusal after return, neighbours of the opcodes
         send(14'h0080, CID_OP_STORE, {7'h00, accum});
         send(14'h00FF, CID_OP_STORE, {7'h7F, accum});
         send(14'h0062, CID_OP_CFG, accum);
         send(14'h0009, CID_OP_RET, stackTopEntry);
         send({7'h01, a}, CID_OP_STORE, {a, accum});
         send(14'h0008, CID_OP_OTHER, 0);
         send(14'h0009, CID_OP_RET, stackTopEntry);
         send(14'h0009, CID_OP_RET, stackTopEntry);
         send(14'h0063, CID_OP_OTHER, 0);
         for (int i = 0; i < 60 && notes.size() > 0; i++) @(posedge clk);
         check("drained", 15'(notes.size()), 15'h0000);
         repeat (3) @(posedge clk);
      end
      reset_dut();
      stop_test();
   end
endmodule

// ---- cid_defines.svh ----
/*
 * opcode encodings, field positions and cycle counts for the decoder
 * assumes: included by bare name from the package and design files
 */
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

// ****************************************************************
// instruction encodings (14-bit words)
// ****************************************************************
`define CID_OP_STORE_MASK   14'h3F80  // store: 00 0000 1fff ffff
`define CID_OP_STORE_VAL    14'h0080
`define CID_OP_RETIRQ       14'h0009  // return from interrupt
`define CID_OP_LOADCFG      14'h0062  // legacy configuration load

// ****************************************************************
// field positions and counts
// ****************************************************************
`define CID_GIE_BIT         7         // enable bit in irq control reg
`define CID_RETIRQ_CYCLES   2         // return takes two cycles
`define CID_CTRL_RESET      8'h00     // irq control reg reset value
`define CID_CFG_RESET       8'hFF     // configuration reg reset value

`endif

// ---- cid_pc_reg.sv ----
/*
 * program counter holding register, loaded from the stack top
 * assumes: single clock, synchronous active-high reset
 */
`timescale 1ns/1ps
`include "cid_defines.svh"

module cid_pc_reg (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // load port
   input  wire logic        load,
   input  wire logic [12:0] loadVal,
   // held value
   output logic      [12:0] pc
);
   import cid_pkg::*;

   // pc register: reset to zero, loaded on request
   always_ff @(posedge clk) begin
      if (srst) begin
         pc <= 13'h0000;
      end else if (load) begin
         pc <= loadVal;
      end
   end

endmodule

// ---- cid_pkg.sv ----
/*
 * types shared by the decoder and its pc register
 * assumes: cid_defines.svh on the include path
 */
`include "cid_defines.svh"

package cid_pkg;

   // ****************************************************************
   // decoded operation classes
   // ****************************************************************
   typedef enum logic [1:0] {
      CID_OP_OTHER,
      CID_OP_STORE,
      CID_OP_RET,
      CID_OP_CFG
   } cid_op_e;

   // register file write port
   typedef struct packed {
      logic       en;    // one-cycle write strobe
      logic [6:0] addr;  // file address
      logic [7:0] data;  // written value
   } cid_fwr_s;

   // stack pop request and returned entry
   typedef struct packed {
      logic        pop;  // one-cycle pop strobe
      logic [12:0] top;  // unused on request side
   } cid_pop_s;

endpackage

// ---- cid_prog_mem.sv ----
/* program memory model feeding words to the decoder
   assumes: bench loads words by push away from the rising edge */
`timescale 1ns/1ps
module cid_prog_mem (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // fetch side
   input  wire logic        slow,
   input  wire logic        instrReady,
   output logic             instrValid,
   output logic [13:0]      instr
);
   logic [13:0] q[$];  // words not yet fetched
   logic        gap;   // idle toggle, slow mode only
   initial begin
      instrValid = 1'b0;
      instr = 14'h2AAA;
      gap = 1'b0;  // an unknown toggle would stall slow mode for good
   end
   // load one word
   task automatic push(input logic [13:0] w);
      q.push_back(w);
   endtask
   // a word stands until taken; idle bus keeps moving so no stale match
   always @(posedge clk) begin
      if (srst) begin
         instrValid <= 1'b0;
      end else if (!(instrValid && !instrReady)) begin
         if (instrValid) void'(q.pop_front());
         gap <= ~gap;
         if (q.size() > 0 && !(slow && gap)) begin
            instrValid <= 1'b1;
            instr <= q[0];
         end else begin
            instrValid <= 1'b0;
            instr <= ~instr;
         end
      end
   end
endmodule
